// *** logic/dmace_top.sv ***
// DMA channel engine: register slave, request handling and transfer sequencer
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module dmace_top (
    input  wire logic                            ref_clk_i,
    input  wire logic                            nrst_i,
    input  wire logic [7:0]                      avs_address_i,
    input  wire logic                            avs_read_i,
    input  wire logic                            avs_write_i,
    input  wire logic [31:0]                     avs_writedata_i,
    output logic      [31:0]                     avs_readdata_o,
    output logic                                 avs_waitrequest_o,
    input  wire logic [dmace_pkg::NSRC-1:0]      xfer_req_i,
    input  wire logic                            pri_req_i,
    output logic                                 bus_req_o,
    input  wire logic                            bus_gnt_i,
    output dmace_pkg::dmace_mem_t                mem_o,
    input  wire logic [dmace_pkg::DW-1:0]        mem_rdata_i,
    input  wire logic                            mem_ack_i,
    output logic                                 cpu_irq_o
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [dmace_pkg::CTL_W-1:0] ctrl_q;
    logic [dmace_pkg::AW-1:0]    mem_q, dst_q, start_mem_q, start_dst_q;
    logic [dmace_pkg::PW-1:0]    per_q;
    logic [dmace_pkg::CW-1:0]    count_q, start_cnt_q, blksz_q, blk_left_q;
    logic                        done_q, pend_q, wait_q, bus_req_q, irq_q;
    logic [31:0]                 rdata_q;
    logic [dmace_pkg::DW-1:0]    data_q;
    dmace_pkg::dmace_mem_t       mem_q_o;
    dmace_pkg::dmace_state_t     state_q, state_d;

    // ************************************************************
    // Bus slave decode
    // ************************************************************
    // One wait cycle per access; the write lands on the edge that ends it
    wire acc   = avs_read_i || avs_write_i;
    wire wr_ok = avs_write_i && !wait_q;
    wire wr_ctl = wr_ok && (avs_address_i == dmace_pkg::OFF_CTRL);
    wire wr_mem = wr_ok && (avs_address_i == dmace_pkg::OFF_MEM);
    wire wr_per = wr_ok && (avs_address_i == dmace_pkg::OFF_PER);
    wire wr_cnt = wr_ok && (avs_address_i == dmace_pkg::OFF_COUNT);
    wire wr_dst = wr_ok && (avs_address_i == dmace_pkg::OFF_DEST);
    wire wr_sts = wr_ok && (avs_address_i == dmace_pkg::OFF_STATUS);
    wire wr_blk = wr_ok && (avs_address_i == dmace_pkg::OFF_BLKSZ);

    wire busy = (state_q != dmace_pkg::S_IDLE);
    wire [31:0] status_w = {29'h0000000, pend_q, busy, done_q};
    wire [31:0] rd_mux =
        (avs_address_i == dmace_pkg::OFF_CTRL)   ? {18'h00000, ctrl_q} :
        (avs_address_i == dmace_pkg::OFF_MEM)    ? {8'h00, mem_q} :
        (avs_address_i == dmace_pkg::OFF_PER)    ? {24'h000000, per_q} :
        (avs_address_i == dmace_pkg::OFF_COUNT)  ? {16'h0000, count_q} :
        (avs_address_i == dmace_pkg::OFF_DEST)   ? {8'h00, dst_q} :
        (avs_address_i == dmace_pkg::OFF_STATUS) ? status_w :
        (avs_address_i == dmace_pkg::OFF_BLKSZ)  ? {16'h0000, blksz_q} : 32'h00000000;

    // ************************************************************
    // Configuration decode
    // ************************************************************
    wire en       = ctrl_q[dmace_pkg::B_EN];
    wire word     = ctrl_q[dmace_pkg::B_SIZE];
    wire [2:0] md = ctrl_q[dmace_pkg::B_MODE_LO +: 3];
    wire [2:0] src = ctrl_q[dmace_pkg::B_SRC_LO +: 3];
    wire m_io     = (md == dmace_pkg::M_IO);
    wire m_idle   = (md == dmace_pkg::M_IDLE);
    wire m_rep    = (md == dmace_pkg::M_REPEAT);
    wire m_burst  = (md == dmace_pkg::M_BURST);
    wire m_steal  = (md == dmace_pkg::M_STEAL);
    wire m_block  = (md == dmace_pkg::M_BLOCK);
    wire m_short  = m_io || m_idle || m_rep;
    wire m_auto   = m_burst || m_steal;
    // In the external-request mode (M_EXT) the external request is the only outside source
    wire [2:0] src_eff = (md == dmace_pkg::M_EXT) ? dmace_pkg::SRC_EXT : src;

    logic src_hit, into_mem;
    dmace_src_sel u_src (
        .req_i      (xfer_req_i),
        .src_i      (src_eff),
        .hit_o      (src_hit),
        .into_mem_o (into_mem)
    );

    // ************************************************************
    // Addresses
    // ************************************************************
    wire [dmace_pkg::AW-1:0] per_full = {dmace_pkg::PER_HIGH, per_q};
    wire dir_in = m_short && into_mem;
    // Short modes: one memory and one fixed peripheral address
    wire [dmace_pkg::AW-1:0] src_addr = dir_in ? per_full : mem_q;
    wire [dmace_pkg::AW-1:0] dst_addr = !m_short ? dst_q :
                                        (into_mem ? mem_q : per_full);
    wire mem_step_en = m_io || m_rep ||
                       (!m_short && ctrl_q[dmace_pkg::B_MEM_STEP]);
    wire dst_step_en = !m_short && ctrl_q[dmace_pkg::B_DST_STEP];

    logic [dmace_pkg::AW-1:0] mem_next, dst_next;
    dmace_addr_step u_mem_step (
        .addr_i (mem_q),
        .en_i   (mem_step_en),
        .dec_i  (ctrl_q[dmace_pkg::B_MEM_DEC]),
        .word_i (word),
        .addr_o (mem_next)
    );
    dmace_addr_step u_dst_step (
        .addr_i (dst_q),
        .en_i   (dst_step_en),
        .dec_i  (ctrl_q[dmace_pkg::B_DST_DEC]),
        .word_i (word),
        .addr_o (dst_next)
    );

    // ************************************************************
    // Completion decode
    // ************************************************************
    wire in_next   = (state_q == dmace_pkg::S_NEXT);
    wire last_unit = !m_block || (blk_left_q == dmace_pkg::CNT_ONE);
    // Zero start count wraps to all ones, so only one ends the run
    wire cnt_end   = last_unit && (count_q == dmace_pkg::CNT_ONE);
    wire finish    = in_next && cnt_end && !m_rep;
    wire rep_wrap  = in_next && cnt_end && m_rep;
    wire blk_end   = in_next && m_block && last_unit;
    wire blk_src   = ctrl_q[dmace_pkg::B_BLK_SRC];
    wire keep_bus  = !finish && !pri_req_i &&
                     (m_burst || (m_block && !last_unit));
    wire start     = en && (m_auto || pend_q);

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dmace_pkg::S_IDLE:  if (start) state_d = dmace_pkg::S_GRANT;
            dmace_pkg::S_GRANT: if (bus_gnt_i) state_d = dmace_pkg::S_READ;
            dmace_pkg::S_READ:  if (mem_ack_i) state_d = dmace_pkg::S_WRITE;
            dmace_pkg::S_WRITE: if (mem_ack_i) state_d = dmace_pkg::S_NEXT;
            dmace_pkg::S_NEXT:  state_d = keep_bus ? dmace_pkg::S_READ : dmace_pkg::S_IDLE;
            default:            state_d = dmace_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) state_q <= dmace_pkg::S_IDLE;
        else state_q <= state_d;
    end

    // ************************************************************
    // Bus slave flops
    // ************************************************************
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q  <= !(acc && wait_q);
            rdata_q <= rd_mux;
        end
    end

    // ************************************************************
    // Control and status
    // ************************************************************
    // A software write of the enable beats the completion clear
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) ctrl_q <= dmace_pkg::CTRL_RST;
        else if (wr_ctl) ctrl_q <= avs_writedata_i[dmace_pkg::CTL_W-1:0];
        else if (finish) ctrl_q[dmace_pkg::B_EN] <= 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) done_q <= 1'b0;
        else if (finish) done_q <= 1'b1;
        else if (wr_sts && avs_writedata_i[dmace_pkg::B_ST_DONE]) done_q <= 1'b0;
    end

    // A request arriving as the last one is taken stays pending
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) pend_q <= 1'b0;
        else if (!en || m_auto) pend_q <= 1'b0;
        else if (src_hit) pend_q <= 1'b1;
        else if (state_q == dmace_pkg::S_IDLE && start) pend_q <= 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) irq_q <= 1'b0;
        else irq_q <= finish && ctrl_q[dmace_pkg::B_IRQ_EN];
    end

    // ************************************************************
    // Addresses and counters
    // ************************************************************
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_q       <= dmace_pkg::ADDR_RST;
            start_mem_q <= dmace_pkg::ADDR_RST;
        end else if (wr_mem) begin
            mem_q       <= avs_writedata_i[dmace_pkg::AW-1:0];
            start_mem_q <= avs_writedata_i[dmace_pkg::AW-1:0];
        end else if (rep_wrap) mem_q <= start_mem_q;
        else if (blk_end && blk_src) mem_q <= start_mem_q;
        else if (in_next) mem_q <= mem_next;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dst_q       <= dmace_pkg::ADDR_RST;
            start_dst_q <= dmace_pkg::ADDR_RST;
        end else if (wr_dst) begin
            dst_q       <= avs_writedata_i[dmace_pkg::AW-1:0];
            start_dst_q <= avs_writedata_i[dmace_pkg::AW-1:0];
        end else if (blk_end && !blk_src) dst_q <= start_dst_q;
        else if (in_next) dst_q <= dst_next;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) per_q <= dmace_pkg::PER_RST;
        else if (wr_per) per_q <= avs_writedata_i[dmace_pkg::PW-1:0];
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_q     <= dmace_pkg::CNT_RST;
            start_cnt_q <= dmace_pkg::CNT_RST;
        end else if (wr_cnt) begin
            count_q     <= avs_writedata_i[dmace_pkg::CW-1:0];
            start_cnt_q <= avs_writedata_i[dmace_pkg::CW-1:0];
        end else if (rep_wrap) count_q <= start_cnt_q;
        else if (in_next && last_unit) count_q <= count_q - dmace_pkg::CNT_ONE;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) blksz_q <= dmace_pkg::BLK_RST;
        else if (wr_blk) blksz_q <= avs_writedata_i[dmace_pkg::CW-1:0];
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) blk_left_q <= dmace_pkg::BLK_RST;
        else if (state_q == dmace_pkg::S_IDLE) blk_left_q <= blksz_q;
        else if (in_next) blk_left_q <= last_unit ? blksz_q : blk_left_q - dmace_pkg::CNT_ONE;
    end

    // ************************************************************
    // System bus master
    // ************************************************************
    // One read then one write per unit; the bus is dropped between units
    // unless burst or an unfinished block keeps it while pri_req_i is low
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) bus_req_q <= 1'b0;
        else bus_req_q <= (state_d != dmace_pkg::S_IDLE);
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) data_q <= '0;
        else if (state_q == dmace_pkg::S_READ && mem_ack_i) data_q <= mem_rdata_i;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) mem_q_o <= '0;
        else begin
            mem_q_o.rd    <= (state_d == dmace_pkg::S_READ);
            mem_q_o.wr    <= (state_d == dmace_pkg::S_WRITE);
            mem_q_o.word  <= word;
            // A burst re-read must use the stepped source, not the one just read
            mem_q_o.addr  <= (state_d == dmace_pkg::S_WRITE) ? dst_addr :
                             (in_next ? mem_next : src_addr);
            mem_q_o.wdata <= (state_q == dmace_pkg::S_READ) ? mem_rdata_i : data_q;
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign bus_req_o         = bus_req_q;
    assign mem_o             = mem_q_o;
    assign cpu_irq_o         = irq_q;

endmodule : dmace_top

// *** logic/dmace_pkg.sv ***
// Constants, field layout and carrier types of the DMA channel engine
package dmace_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int AW = 24;
    localparam int PW = 8;
    localparam int CW = 16;
    localparam int DW = 16;
    localparam int NSRC = 7;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_MEM    = 8'h04;
    localparam logic [7:0] OFF_PER    = 8'h08;
    localparam logic [7:0] OFF_COUNT  = 8'h0C;
    localparam logic [7:0] OFF_DEST   = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_BLKSZ  = 8'h18;

    // ************************************************************
    // Control fields
    // ************************************************************
    localparam int CTL_W      = 14;
    localparam int B_EN       = 0;
    localparam int B_IRQ_EN   = 1;
    localparam int B_SIZE     = 2;
    localparam int B_MEM_DEC  = 3;
    localparam int B_MEM_STEP = 4;
    localparam int B_MODE_LO  = 5;
    localparam int B_SRC_LO   = 8;
    localparam int B_DST_DEC  = 11;
    localparam int B_DST_STEP = 12;
    localparam int B_BLK_SRC  = 13;
    localparam int B_ST_DONE  = 0;
    localparam int B_ST_BUSY  = 1;
    localparam int B_ST_PEND  = 2;

    localparam logic [CTL_W-1:0] CTRL_RST = 14'h0000;
    localparam logic [AW-1:0]    ADDR_RST = 24'h000000;
    localparam logic [PW-1:0]    PER_RST  = 8'h00;
    localparam logic [CW-1:0]    CNT_RST  = 16'h0000;
    localparam logic [CW-1:0]    CNT_ONE  = 16'h0001;
    localparam logic [CW-1:0]    BLK_RST  = 16'h0001;
    localparam logic [AW-PW-1:0] PER_HIGH = 16'hFFFF;
    localparam logic [AW-1:0]    STEP_B   = 24'h000001;
    localparam logic [AW-1:0]    STEP_W   = 24'h000002;

    // ************************************************************
    // Modes and activation sources
    // ************************************************************
    typedef enum logic [2:0] {
        M_IO     = 3'h0,
        M_IDLE   = 3'h1,
        M_REPEAT = 3'h2,
        M_BURST  = 3'h3,
        M_STEAL  = 3'h4,
        M_EXT    = 3'h5,
        M_BLOCK  = 3'h6
    } dmace_mode_t;

    localparam logic [2:0] SRC_TMR0  = 3'h0;
    localparam logic [2:0] SRC_TMR1  = 3'h1;
    localparam logic [2:0] SRC_TMR2  = 3'h2;
    localparam logic [2:0] SRC_SER_TX = 3'h3;
    localparam logic [2:0] SRC_SER_RX = 3'h4;
    localparam logic [2:0] SRC_CONV  = 3'h5;
    localparam logic [2:0] SRC_EXT   = 3'h6;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_GRANT = 3'b001,
        S_READ  = 3'b011,
        S_WRITE = 3'b010,
        S_NEXT  = 3'b110
    } dmace_state_t;

    // ************************************************************
    // System bus request carrier
    // ************************************************************
    typedef struct packed {
        logic [AW-1:0] addr;
        logic          rd;
        logic          wr;
        logic          word;
        logic [DW-1:0] wdata;
    } dmace_mem_t;

endpackage : dmace_pkg

// *** logic/dmace_src_sel.sv ***
// Activation source selection and transfer direction inference
`timescale 1ns/1ps
module dmace_src_sel (
    input  wire logic [dmace_pkg::NSRC-1:0] req_i,
    input  wire logic [2:0]                 src_i,
    output logic                            hit_o,
    output logic                            into_mem_o
);

    // ************************************************************
    // Selection
    // ************************************************************
    assign hit_o = req_i[src_i];
    // Receive-full and converter-end read the peripheral side
    assign into_mem_o = (src_i == dmace_pkg::SRC_SER_RX)
                     || (src_i == dmace_pkg::SRC_CONV);

endmodule : dmace_src_sel

// *** logic/dmace_addr_step.sv ***
// Address stepper: holds, increments or decrements by one transfer unit
`timescale 1ns/1ps
module dmace_addr_step #(
    parameter int AW = dmace_pkg::AW
) (
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          en_i,
    input  wire logic          dec_i,
    input  wire logic          word_i,
    output logic [AW-1:0]      addr_o
);

    // ************************************************************
    // Step
    // ************************************************************
    logic [AW-1:0] step;
    assign step   = word_i ? dmace_pkg::STEP_W[AW-1:0] : dmace_pkg::STEP_B[AW-1:0];
    assign addr_o = !en_i ? addr_i : (dec_i ? addr_i - step : addr_i + step);

endmodule : dmace_addr_step

// *** tb/dmace_top_properties.sv ***
// Port-level concurrent checks of the DMA channel engine
`timescale 1ns/1ps
module dmace_top_props (
    input wire logic                     ref_clk_i,
    input wire logic                     nrst_i,
    input wire logic                     avs_read_i,
    input wire logic                     avs_write_i,
    input wire logic                     avs_waitrequest_o,
    input wire logic                     bus_req_o,
    input wire logic                     bus_gnt_i,
    input wire dmace_pkg::dmace_mem_t    mem_o,
    input wire logic [dmace_pkg::DW-1:0] mem_rdata_i,
    input wire logic                     mem_ack_i,
    input wire logic                     cpu_irq_o
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    chk_slave_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("slave answer late");
    chk_slave_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait low too long");
    chk_read_held: assert property (mem_o.rd && !mem_ack_i |=> mem_o.rd && $stable(mem_o.addr))
        else $error("read not held");
    chk_write_follows: assert property (mem_o.rd && mem_ack_i |=> mem_o.wr && !mem_o.rd
        && mem_o.wdata[7:0] == $past(mem_rdata_i[7:0])) else $error("write wrong");
    chk_read_granted: assert property ($rose(mem_o.rd) |-> bus_req_o && $past(bus_gnt_i))
        else $error("read without grant");
    chk_irq_at_end: assert property (cpu_irq_o |-> $past(mem_ack_i, 2) && !$past(cpu_irq_o))
        else $error("irq misplaced");
    chk_no_bus_use: assert property (!bus_req_o |-> !mem_o.rd && !mem_o.wr)
        else $error("access without bus");
    chk_unit_bound: assert property ($rose(mem_o.rd) |-> ##[1:40] (mem_o.wr && mem_ack_i))
        else $error("unit not finished");
    cover property (cpu_irq_o);
    cover property (mem_o.wr && mem_ack_i && mem_o.word);
    cover property ($fell(bus_req_o) ##[1:3] $rose(bus_req_o));
endmodule : dmace_top_props

// *** tb/dmace_mem_model.sv ***
// System bus and memory model beside the DMA channel engine
`timescale 1ns/1ps
module dmace_mem_model (
    input  wire logic                     clk_i,
    input  wire logic                     nrst_i,
    input  wire logic                     bus_req_i,
    input  wire dmace_pkg::dmace_mem_t    mem_i,
    output logic                          gnt_o,
    output logic                          ack_o,
    output logic [dmace_pkg::DW-1:0]      rdata_o
);
    // Answers alternate prompt and slow; idle data toggles so stale data never matches
    logic [1:0] wait_q;
    logic       slow_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gnt_o   <= 1'b0;
            ack_o   <= 1'b0;
            wait_q  <= 2'h0;
            slow_q  <= 1'b0;
            rdata_o <= 16'hFFFF;
        end else begin
            gnt_o   <= bus_req_i;
            ack_o   <= 1'b0;
            rdata_o <= ~rdata_o;
            if ((mem_i.rd || mem_i.wr) && !ack_o) begin
                if (wait_q != 2'h0) begin
                    wait_q <= wait_q - 2'h1;
                end else begin
                    ack_o   <= 1'b1;
                    rdata_o <= mem_i.addr[15:0] ^ 16'h5A3C;
                    slow_q  <= !slow_q;
                    wait_q  <= slow_q ? 2'h0 : 2'h3;
                end
            end
        end
    end
endmodule : dmace_mem_model

// *** tb/dmace_top_tb.sv ***
// Self-checking bench of the DMA channel engine
`timescale 1ns/1ps
module dmace_top_tb;
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, rd_s = 1'b0, wr_s = 1'b0, w_q = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [6:0] xreq = 7'h00;
    logic [31:0] wd = 32'h0, rdat, rv, x = 32'h0000001C;
    logic wait_r, breq, gnt, ack, irq, breq_q = 1'b0, pri = 1'b0;
    logic [15:0] mrd;
    logic [23:0] src_seen;
    logic [47:0] nt, notes[$];
    dmace_pkg::dmace_mem_t mem;
    int num_errors = 0, checks_done = 0, cyc = 0, irqs = 0, rises = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    dmace_top dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_r), .xfer_req_i(xreq), .pri_req_i(pri), .bus_req_o(breq),
        .bus_gnt_i(gnt), .mem_o(mem), .mem_rdata_i(mrd), .mem_ack_i(ack), .cpu_irq_o(irq));
    dmace_mem_model u_mem (.clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_req_i(breq), .mem_i(mem),
        .gnt_o(gnt), .ack_o(ack), .rdata_o(mrd));
    // ************************************************************
    // Tasks
    // ************************************************************
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : rnd
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge ref_clk_i);
        adr  <= a;
        wd   <= d;
        wr_s <= w;
        rd_s <= !w;
        @(posedge ref_clk_i);
        while (wait_r !== 1'b0) @(posedge ref_clk_i);
        q = rdat;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask : acc
    task automatic idle_wait();
        logic [31:0] q;
        q = 32'h6;
        repeat (4) @(posedge ref_clk_i);
        while (q[2:1] !== 2'b00) begin
            acc(1'b0, dmace_pkg::OFF_STATUS, 32'h0, q);
            // Units are one idle cycle apart: confirm idle twice
            if (q[2:1] === 2'b00) acc(1'b0, dmace_pkg::OFF_STATUS, 32'h0, q);
        end
    endtask : idle_wait
    // One channel set-up, its requests and the expected units, then register checks
    task automatic run(input logic [2:0] s, input dmace_pkg::dmace_mode_t md,
                       input logic w, input logic dc, input logic ie,
                       input logic [15:0] cnt, input int n);
        logic [31:0] r, p;
        logic [23:0] ma;
        logic au, fin;
        int k, i0, b0, st, u;
        r = rnd();
        p = rnd();
        au = md inside {dmace_pkg::M_BURST, dmace_pkg::M_STEAL};
        fin = md != dmace_pkg::M_REPEAT && cnt != 16'h0000 && (au || n >= cnt);
        st = (md == dmace_pkg::M_IDLE) ? 0 : (w ? 2 : 1);
        u = fin ? int'(cnt) : n;
        ma = r[23:0];
        for (k = 0; k < u; k++) begin
            if (md >= dmace_pkg::M_BURST) notes.push_back({ma, p[23:0] +
                24'(md == dmace_pkg::M_BLOCK ? 0 : k * st)});
            else if (s == dmace_pkg::SRC_SER_RX || s == dmace_pkg::SRC_CONV)
                notes.push_back({16'hFFFF, p[7:0], ma});
            else notes.push_back({ma, 16'hFFFF, p[7:0]});
            ma = dc ? ma - 24'(st) : ma + 24'(st);
            if (md == dmace_pkg::M_REPEAT && (k + 1) % cnt == 0) ma = r[23:0];
        end
        acc(1'b1, dmace_pkg::OFF_MEM, {8'h00, r[23:0]}, rv);
        acc(1'b1, dmace_pkg::OFF_DEST, {8'h00, p[23:0]}, rv);
        acc(1'b1, dmace_pkg::OFF_PER, {24'h0, p[7:0]}, rv);
        acc(1'b1, dmace_pkg::OFF_COUNT, {16'h0, cnt}, rv);
        w_q = w;
        i0 = irqs;
        b0 = rises;
        acc(1'b1, dmace_pkg::OFF_CTRL, {20'h1, 1'b0, s, md, 1'b1, dc, w, ie, 1'b1}, rv);
        for (k = 0; k < n; k++) begin
            @(posedge ref_clk_i);
            xreq <= 7'h01 << s;
            @(posedge ref_clk_i);
            xreq <= 7'h00;
            idle_wait();
        end
        idle_wait();
        check("irq count", 32'(irqs - i0), (ie && fin) ? 32'h1 : 32'h0);
        acc(1'b0, dmace_pkg::OFF_CTRL, 32'h0, rv);
        check("enable", {31'h0, rv[0]}, {31'h0, !fin});
        acc(1'b0, dmace_pkg::OFF_COUNT, 32'h0, rv);
        check("count", rv, {16'h0, fin ? 16'h0 : 16'(md == dmace_pkg::M_REPEAT ?
            cnt - n % cnt : cnt - n)});
        if (au) check("bus takes", 32'(rises - b0),
            md == dmace_pkg::M_STEAL || pri ? 32'(cnt) : 32'h1);
        check("left units", 32'(notes.size()), 32'h0);
        acc(1'b1, dmace_pkg::OFF_CTRL, 32'h0, rv);
    endtask : run
    // ************************************************************
    // Monitor, timeout and sequence
    // ************************************************************
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
        if (breq && !breq_q) rises++;
        breq_q = breq;
        if (irq === 1'b1) irqs++;
        if (mem.rd && ack) src_seen = mem.addr;
        if (mem.wr && ack) begin
            if (notes.size() == 0) check("spare unit", 32'h1, 32'h0);
            else begin
                nt = notes.pop_front();
                check("source", {8'h0, src_seen}, {8'h0, nt[47:24]});
                check("dest", {8'h0, mem.addr}, {8'h0, nt[23:0]});
                check("data", {16'h0, mem.wdata & (w_q ? 16'hFFFF : 16'h00FF)},
                    {16'h0, (nt[39:24] ^ 16'h5A3C) & (w_q ? 16'hFFFF : 16'h00FF)});
            end
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        acc(1'b0, 8'h1C, 32'h0, rv);
        check("unmapped", rv, 32'h0);
        acc(1'b0, dmace_pkg::OFF_BLKSZ, 32'h0, rv);
        check("block size", rv, 32'h1);
        for (int s = 0; s < 7; s++) run(3'(s), dmace_pkg::M_IO, 0, 0, 1, 16'h0001, 2);
        run(dmace_pkg::SRC_TMR1, dmace_pkg::M_IO, 1, 1, 1, 16'h0003, 3);
        run(dmace_pkg::SRC_SER_RX, dmace_pkg::M_IDLE, 0, 0, 0, 16'h0002, 2);
        run(dmace_pkg::SRC_TMR2, dmace_pkg::M_REPEAT, 0, 0, 1, 16'h0002, 3);
        run(dmace_pkg::SRC_EXT, dmace_pkg::M_IO, 0, 0, 1, 16'h0000, 1);
        run(dmace_pkg::SRC_EXT, dmace_pkg::M_EXT, 0, 0, 1, 16'h0001, 1);
        run(dmace_pkg::SRC_CONV, dmace_pkg::M_BLOCK, 0, 0, 1, 16'h0002, 2);
        run(dmace_pkg::SRC_TMR0, dmace_pkg::M_STEAL, 0, 0, 1, 16'h0002, 0);
        run(dmace_pkg::SRC_TMR0, dmace_pkg::M_BURST, 1, 0, 1, 16'h0002, 0);
        pri <= 1'b1;
        run(dmace_pkg::SRC_TMR0, dmace_pkg::M_BURST, 0, 0, 1, 16'h0002, 0);
        stop_test();
    end
endmodule : dmace_top_tb
bind dmace_top dmace_top_props u_props (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .bus_req_o(bus_req_o), .bus_gnt_i(bus_gnt_i), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i), .cpu_irq_o(cpu_irq_o));
